//--- aficf_flags.sv
// Interrupt status flags and the sequencer-only custom interrupt generation register.
//
// Functional notes
// - Bits 9..12 show custom interrupts 0..3.
// - Bit 8 shows the variance interrupt.
// - Bit 7 shows the mean interrupt.
// - Bit 6 sticky: consecutive results exceed delta.
// - Bit 5 set: result above upper limit.
// - Bit 4 set: result below lower limit.
// - Bit 3 shows the temperature result interrupt.
// - Bit 2 shows the sinc2 ready interrupt.
// - Bit 1 shows the DFT result interrupt.
// - Bit 0 shows the converter result interrupt.
// - Generation register written by sequencer only.
// - Host writes to generation register ignored.
// - Writing 1 to bits 0..3 triggers interrupts.
// - Generation register resets 0x10; upper bits reserved.
// - Bit 15 sequence end, bit 16 timeout.
// - Bit 13 bootload done; bit 14 reserved.
`timescale 1ns/1ps
`default_nettype none

module aficf_flags #(
    parameter int DATA_W = 16
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic conv_result_in,
    input wire logic dft_result_in,
    input wire logic sinc2_ready_in,
    input wire logic temp_result_in,
    input wire logic mean_irq_in,
    input wire logic variance_irq_in,
    input wire logic bootload_done_in,
    input wire logic seq_end_in,
    input wire logic seq_timeout_in,
    input wire logic conv_valid_in,
    input wire logic [DATA_W-1:0] conv_data_in,
    input wire logic [DATA_W-1:0] conv_upper_limit_in,
    input wire logic [DATA_W-1:0] conv_lower_limit_in,
    input wire logic [DATA_W-1:0] conv_delta_limit_in,
    input wire logic [31:0] flag_clear_in,
    input wire logic seq_wr_in,
    input wire logic seq_rd_in,
    input wire logic [15:0] seq_addr_in,
    input wire logic [31:0] seq_wdata_in,
    output logic [31:0] seq_rdata_out,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [15:0] host_addr_in,
    input wire logic [31:0] host_wdata_in,
    output logic [31:0] host_rdata_out,
    output logic [31:0] irq_flag_status_out
);

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [31:0] status;
        logic [DATA_W-1:0] prev;
        logic prev_valid;
        logic [31:0] seq_rdata;
        logic [31:0] host_rdata;
    } aficf_state_s;

    aficf_state_s cur_q;
    aficf_state_s nxt_d;
    logic [31:0] set_vec;
    logic gen_seq_wr;
    logic [DATA_W-1:0] diff;
    logic delta_hit;
    logic unused_host;

    function automatic logic gen_hit(input logic [15:0] addr);
        gen_hit = (addr == aficf_pkg::CUSTOM_IRQ_GENERATE_OFS);
    endfunction

    // ************************************************************
    // Flag update.
    // ************************************************************
    always_comb begin
        nxt_d = cur_q;
        gen_seq_wr = seq_wr_in && gen_hit(seq_addr_in);
        unused_host = host_wr_in ^ (|host_wdata_in);
        diff = (conv_data_in >= cur_q.prev) ? (conv_data_in - cur_q.prev)
                                            : (cur_q.prev - conv_data_in);
        delta_hit = conv_valid_in && cur_q.prev_valid && (diff > conv_delta_limit_in);
        set_vec = 32'h00000000;
        set_vec[aficf_pkg::CONV_RESULT_POS] = conv_result_in;
        set_vec[aficf_pkg::DFT_RESULT_POS] = dft_result_in;
        set_vec[aficf_pkg::SINC2_READY_POS] = sinc2_ready_in;
        set_vec[aficf_pkg::TEMP_RESULT_POS] = temp_result_in;
        set_vec[aficf_pkg::CONV_MIN_FAIL_POS] =
            conv_valid_in && (conv_data_in < conv_lower_limit_in);
        set_vec[aficf_pkg::CONV_MAX_FAIL_POS] =
            conv_valid_in && (conv_data_in > conv_upper_limit_in);
        set_vec[aficf_pkg::CONV_DELTA_FAIL_POS] = delta_hit;
        set_vec[aficf_pkg::MEAN_IRQ_POS] = mean_irq_in;
        set_vec[aficf_pkg::VARIANCE_IRQ_POS] = variance_irq_in;
        set_vec[aficf_pkg::BOOTLOAD_DONE_POS] = bootload_done_in;
        set_vec[aficf_pkg::SEQ_END_POS] = seq_end_in;
        set_vec[aficf_pkg::SEQ_TIMEOUT_POS] = seq_timeout_in;
        if (gen_seq_wr) begin
            set_vec[aficf_pkg::CUSTOM_IRQ0_POS +: aficf_pkg::CUSTOM_IRQ_NUM] =
                seq_wdata_in[aficf_pkg::GP_TRIGGER_LSB +: aficf_pkg::CUSTOM_IRQ_NUM];
        end
        // Set wins over a clear in the same cycle.
        nxt_d.status = ((cur_q.status & ~flag_clear_in) | set_vec)
                       & aficf_pkg::IRQ_FLAG_IMPL_MASK;
        if (conv_valid_in) begin
            nxt_d.prev = conv_data_in;
            nxt_d.prev_valid = 1'b1;
        end
        nxt_d.seq_rdata = 32'h00000000;
        if (seq_rd_in && gen_hit(seq_addr_in)) begin
            nxt_d.seq_rdata = {aficf_pkg::CUSTOM_IRQ_GENERATE_RSVD,
                cur_q.status[aficf_pkg::CUSTOM_IRQ0_POS +: aficf_pkg::CUSTOM_IRQ_NUM]};
        end
        // Host reads of the generation register return zero.
        nxt_d.host_rdata = 32'h00000000;
        if (host_rd_in && !gen_hit(host_addr_in)) begin
            nxt_d.host_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur_q.status <= aficf_pkg::IRQ_FLAG_STATUS_RST;
            cur_q.prev <= '0;
            cur_q.prev_valid <= 1'b0;
            cur_q.seq_rdata <= 32'h00000000;
            cur_q.host_rdata <= 32'h00000000;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign irq_flag_status_out = cur_q.status;
    assign seq_rdata_out = cur_q.seq_rdata;
    assign host_rdata_out = cur_q.host_rdata;

    // ************************************************************
    // Assertions.
    // ************************************************************
    logic [aficf_pkg::CUSTOM_IRQ_NUM-1:0] custom_flags;
    assign custom_flags =
        irq_flag_status_out[aficf_pkg::CUSTOM_IRQ0_POS +: aficf_pkg::CUSTOM_IRQ_NUM];

    sequence s_gen_write;
        seq_wr_in && gen_hit(seq_addr_in);
    endsequence

    sequence s_custom_seen;
        custom_flags
            == ($past(seq_wdata_in[aficf_pkg::GP_TRIGGER_LSB +: aficf_pkg::CUSTOM_IRQ_NUM])
                | $past(custom_flags));
    endsequence

    property p_custom_set;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_gen_write ##0 (flag_clear_in == 32'h00000000) |=> s_custom_seen;
    endproperty
    a_custom_set: assert property (p_custom_set) else $error("custom flag not set");

    property p_host_ignored;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        host_wr_in && !seq_wr_in && (flag_clear_in == 32'h00000000)
        |=> $stable(irq_flag_status_out[12:9]);
    endproperty
    a_host_ignored: assert property (p_host_ignored) else $error("host write changed flags");

    property p_custom_hold;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        irq_flag_status_out[aficf_pkg::CUSTOM_IRQ0_POS] && !flag_clear_in[aficf_pkg::CUSTOM_IRQ0_POS]
        |=> irq_flag_status_out[aficf_pkg::CUSTOM_IRQ0_POS];
    endproperty
    a_custom_hold: assert property (p_custom_hold) else $error("custom flag dropped");

    property p_max_fail;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        conv_valid_in && (conv_data_in > conv_upper_limit_in)
        |=> irq_flag_status_out[aficf_pkg::CONV_MAX_FAIL_POS];
    endproperty
    a_max_fail: assert property (p_max_fail) else $error("max fail missed");

    property p_min_fail;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        conv_valid_in && (conv_data_in < conv_lower_limit_in)
        |=> irq_flag_status_out[aficf_pkg::CONV_MIN_FAIL_POS];
    endproperty
    a_min_fail: assert property (p_min_fail) else $error("min fail missed");

    property p_delta_fail;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        conv_valid_in ##1 (conv_valid_in && (diff > conv_delta_limit_in))
        |=> irq_flag_status_out[aficf_pkg::CONV_DELTA_FAIL_POS];
    endproperty
    a_delta_fail: assert property (p_delta_fail) else $error("delta fail missed");

    property p_delta_sticky;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        irq_flag_status_out[aficf_pkg::CONV_DELTA_FAIL_POS]
            && !flag_clear_in[aficf_pkg::CONV_DELTA_FAIL_POS]
        |=> irq_flag_status_out[aficf_pkg::CONV_DELTA_FAIL_POS];
    endproperty
    a_delta_sticky: assert property (p_delta_sticky) else $error("delta flag dropped");

    property p_event_flags;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        1'b1 |=> ((irq_flag_status_out & $past(set_vec)) == $past(set_vec));
    endproperty
    a_event_flags: assert property (p_event_flags) else $error("event flag missed");

    property p_reserved_zero;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (irq_flag_status_out & ~aficf_pkg::IRQ_FLAG_IMPL_MASK) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag set");

    property p_gen_read;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        seq_rd_in && gen_hit(seq_addr_in)
        |=> seq_rdata_out[31:4] == aficf_pkg::CUSTOM_IRQ_GENERATE_RSVD;
    endproperty
    a_gen_read: assert property (p_gen_read) else $error("reserved bits wrong");

    property p_ev_res;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        conv_result_in |=> irq_flag_status_out[aficf_pkg::CONV_RESULT_POS];
    endproperty
    a_ev_res: assert property (p_ev_res) else $error("result flag missed");

    property p_ev_dft;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        dft_result_in |=> irq_flag_status_out[aficf_pkg::DFT_RESULT_POS];
    endproperty
    a_ev_dft: assert property (p_ev_dft) else $error("dft flag missed");

    property p_ev_sinc2;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        sinc2_ready_in |=> irq_flag_status_out[aficf_pkg::SINC2_READY_POS];
    endproperty
    a_ev_sinc2: assert property (p_ev_sinc2) else $error("sinc2 flag missed");

    property p_ev_temp;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        temp_result_in |=> irq_flag_status_out[aficf_pkg::TEMP_RESULT_POS];
    endproperty
    a_ev_temp: assert property (p_ev_temp) else $error("temperature flag missed");

    property p_ev_mean;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        mean_irq_in |=> irq_flag_status_out[aficf_pkg::MEAN_IRQ_POS];
    endproperty
    a_ev_mean: assert property (p_ev_mean) else $error("mean flag missed");

    property p_ev_var;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        variance_irq_in |=> irq_flag_status_out[aficf_pkg::VARIANCE_IRQ_POS];
    endproperty
    a_ev_var: assert property (p_ev_var) else $error("variance flag missed");

    property p_ev_boot;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        bootload_done_in |=> irq_flag_status_out[aficf_pkg::BOOTLOAD_DONE_POS];
    endproperty
    a_ev_boot: assert property (p_ev_boot) else $error("bootload flag missed");

    property p_ev_end;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        seq_end_in |=> irq_flag_status_out[aficf_pkg::SEQ_END_POS];
    endproperty
    a_ev_end: assert property (p_ev_end) else $error("sequence end flag missed");

    property p_ev_tmo;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        seq_timeout_in |=> irq_flag_status_out[aficf_pkg::SEQ_TIMEOUT_POS];
    endproperty
    a_ev_tmo: assert property (p_ev_tmo) else $error("timeout flag missed");

    property p_custom_quiet;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !(seq_wr_in && gen_hit(seq_addr_in))
        |=> (custom_flags & ~$past(custom_flags)) == '0;
    endproperty
    a_custom_quiet: assert property (p_custom_quiet) else $error("custom flag set unasked");

    property p_max_quiet;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !irq_flag_status_out[aficf_pkg::CONV_MAX_FAIL_POS]
            && !(conv_valid_in && (conv_data_in > conv_upper_limit_in))
        |=> !irq_flag_status_out[aficf_pkg::CONV_MAX_FAIL_POS];
    endproperty
    a_max_quiet: assert property (p_max_quiet) else $error("max flag set unasked");

    property p_min_quiet;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !irq_flag_status_out[aficf_pkg::CONV_MIN_FAIL_POS]
            && !(conv_valid_in && (conv_data_in < conv_lower_limit_in))
        |=> !irq_flag_status_out[aficf_pkg::CONV_MIN_FAIL_POS];
    endproperty
    a_min_quiet: assert property (p_min_quiet) else $error("min flag set unasked");

    property p_seq_rdata_idle;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !(seq_rd_in && gen_hit(seq_addr_in)) |=> seq_rdata_out == 32'h00000000;
    endproperty
    a_seq_rdata_idle: assert property (p_seq_rdata_idle) else $error("read data not idle");

endmodule

`default_nettype wire

//--- aficf_pkg.sv
// Package with offsets, field positions and reset values of the interrupt flag block.
package aficf_pkg;
    localparam logic [15:0] CUSTOM_IRQ_GENERATE_OFS = 16'h209c;
    localparam logic [31:0] CUSTOM_IRQ_GENERATE_RST = 32'h00000010;
    localparam logic [27:0] CUSTOM_IRQ_GENERATE_RSVD = 28'h0000001;
    localparam logic [31:0] IRQ_FLAG_STATUS_RST = 32'h00000000;
    localparam int CONV_RESULT_POS = 0;
    localparam int DFT_RESULT_POS = 1;
    localparam int SINC2_READY_POS = 2;
    localparam int TEMP_RESULT_POS = 3;
    localparam int CONV_MIN_FAIL_POS = 4;
    localparam int CONV_MAX_FAIL_POS = 5;
    localparam int CONV_DELTA_FAIL_POS = 6;
    localparam int MEAN_IRQ_POS = 7;
    localparam int VARIANCE_IRQ_POS = 8;
    localparam int CUSTOM_IRQ0_POS = 9;
    localparam int CUSTOM_IRQ_NUM = 4;
    localparam int BOOTLOAD_DONE_POS = 13;
    localparam int SEQ_END_POS = 15;
    localparam int SEQ_TIMEOUT_POS = 16;
    localparam logic [31:0] IRQ_FLAG_IMPL_MASK = 32'h0001bfff;
    localparam int GP_TRIGGER_LSB = 0;
endpackage

//--- aficf_far_model.sv
// Model of the sequencer and the SPI host that reach the flag block's registers.
`timescale 1ns/1ps
`default_nettype none

module aficf_far_model (
    input wire logic core_clk_in,
    input wire logic [31:0] seq_rdata_in,
    input wire logic [31:0] host_rdata_in,
    output logic seq_wr_out,
    output logic seq_rd_out,
    output logic host_wr_out,
    output logic host_rd_out,
    output logic [15:0] addr_out,
    output logic [31:0] wdata_out
);
    initial begin
        seq_wr_out = 1'b0;
        seq_rd_out = 1'b0;
        host_wr_out = 1'b0;
        host_rd_out = 1'b0;
        addr_out = 16'h0000;
        wdata_out = 32'h00000000;
    end

    // One access, launched and released on falling edges; read data is taken one cycle on.
    task automatic acc(input logic host, input logic wr, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(negedge core_clk_in);
        seq_wr_out = !host && wr;
        seq_rd_out = !host && !wr;
        host_wr_out = host && wr;
        host_rd_out = host && !wr;
        addr_out = a;
        wdata_out = d;
        @(negedge core_clk_in);
        q = host ? host_rdata_in : seq_rdata_in;
        seq_wr_out = 1'b0;
        seq_rd_out = 1'b0;
        host_wr_out = 1'b0;
        host_rd_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
endmodule
`default_nettype wire

//--- afe_irq_flags_and_custom_irq_tb.sv
// Self-checking testbench of the interrupt flag block.
`timescale 1ns/1ps
`default_nettype none

module afe_irq_flags_and_custom_irq_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] ev = 9'h000;
    logic cv = 1'b0;
    logic [15:0] cd = 16'h0000;
    logic [31:0] clr = 32'h00000000;
    logic [15:0] up = 16'h0064;
    logic [15:0] lo = 16'h000a;
    logic [15:0] dl = 16'h0014;
    logic [31:0] q;
    int fails = 0;
    int total_checks = 0;
    int pos [9] = '{0, 1, 2, 3, 7, 8, 13, 15, 16};
    wire logic sw, sr, hw, hr;
    wire logic [15:0] a;
    wire logic [31:0] d, srd, hrd, st;

    always #12.5 clk = ~clk;

    aficf_flags i_dut (.core_clk_in(clk), .sys_rst_in(rst), .conv_result_in(ev[0]),
        .dft_result_in(ev[1]), .sinc2_ready_in(ev[2]), .temp_result_in(ev[3]),
        .mean_irq_in(ev[4]), .variance_irq_in(ev[5]), .bootload_done_in(ev[6]),
        .seq_end_in(ev[7]), .seq_timeout_in(ev[8]), .conv_valid_in(cv), .conv_data_in(cd),
        .conv_upper_limit_in(up), .conv_lower_limit_in(lo),
        .conv_delta_limit_in(dl), .flag_clear_in(clr), .seq_wr_in(sw), .seq_rd_in(sr),
        .seq_addr_in(a), .seq_wdata_in(d), .seq_rdata_out(srd), .host_wr_in(hw),
        .host_rd_in(hr), .host_addr_in(a), .host_wdata_in(d), .host_rdata_out(hrd),
        .irq_flag_status_out(st));

    aficf_far_model i_far (.core_clk_in(clk), .seq_rdata_in(srd), .host_rdata_in(hrd),
        .seq_wr_out(sw), .seq_rd_out(sr), .host_wr_out(hw), .host_rd_out(hr),
        .addr_out(a), .wdata_out(d));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic clear(input logic [31:0] m);
        @(negedge clk);
        clr = m;
        @(negedge clk);
        clr = 32'h00000000;
    endtask

    task automatic t_reset();
        chk(st, aficf_pkg::IRQ_FLAG_STATUS_RST);
        i_far.acc(1'b0, 1'b0, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'h0, q);
        chk(q, aficf_pkg::CUSTOM_IRQ_GENERATE_RST);
    endtask

    task automatic t_events();
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            ev = 9'h001 << i;
            @(negedge clk);
            ev = 9'h000;
            chk(st, 32'h1 << pos[i]);
            clear(32'h1 << pos[i]);
            chk(st, 32'h0);
        end
    endtask

    task automatic t_set_wins();
        @(negedge clk);
        ev = 9'h001;
        clr = 32'h00000001;
        @(negedge clk);
        ev = 9'h000;
        clr = 32'h00000000;
        chk(st, 32'h00000001);
        clear(32'h00000001);
        chk(st, 32'h00000000);
    endtask

    task automatic t_custom();
        i_far.acc(1'b0, 1'b1, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'h5, q);
        chk(st, 32'h00000a00);
        i_far.acc(1'b1, 1'b1, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'ha, q);
        chk(st, 32'h00000a00);
        i_far.acc(1'b0, 1'b1, 16'h20a0, 32'ha, q);
        chk(st, 32'h00000a00);
        i_far.acc(1'b0, 1'b0, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'h0, q);
        chk(q, 32'h00000015);
        i_far.acc(1'b1, 1'b0, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'h0, q);
        chk(q, 32'h00000000);
        i_far.acc(1'b0, 1'b0, 16'h20a0, 32'h0, q);
        chk(q, 32'h00000000);
        i_far.acc(1'b0, 1'b1, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'ha, q);
        chk(st, 32'h00001e00);
        clear(32'h00001e00);
        chk(st, 32'h0);
    endtask

    task automatic conv(input logic [15:0] v, input logic [2:0] e);
        @(negedge clk);
        cv = 1'b1;
        cd = v;
        @(negedge clk);
        cv = 1'b0;
        chk({29'h0, st[6:4]}, {29'h0, e});
    endtask

    task automatic conv_pair(input logic [15:0] v0, input logic [15:0] v1, input logic [2:0] e);
        @(negedge clk);
        cv = 1'b1;
        cd = v0;
        @(negedge clk);
        cd = v1;
        @(negedge clk);
        cv = 1'b0;
        chk({29'h0, st[6:4]}, {29'h0, e});
    endtask

    task automatic t_midreset();
        @(negedge clk);
        ev = 9'h001;
        @(negedge clk);
        ev = 9'h000;
        chk(st, 32'h00000001);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        up = 16'h0064;
        lo = 16'h000a;
        dl = 16'h0014;
        chk(st, aficf_pkg::IRQ_FLAG_STATUS_RST);
        i_far.acc(1'b0, 1'b0, aficf_pkg::CUSTOM_IRQ_GENERATE_OFS, 32'h0, q);
        chk(q, aficf_pkg::CUSTOM_IRQ_GENERATE_RST);
        conv(16'd60, 3'b000);
    endtask

    task automatic t_limits();
        conv(16'd50, 3'b000);
        conv(16'd60, 3'b000);
        conv(16'd90, 3'b100);
        conv(16'd95, 3'b100);
        clear(32'h70);
        conv(16'd100, 3'b000);
        conv(16'd121, 3'b110);
        clear(32'h70);
        conv(16'd5, 3'b101);
        clear(32'h70);
        conv(16'd10, 3'b000);
        conv_pair(16'd20, 16'd45, 3'b100);
        clear(32'h70);
        up = 16'h00c8;
        lo = 16'h0005;
        dl = 16'h00ff;
        conv(16'd150, 3'b000);
        conv(16'd201, 3'b010);
        clear(32'h70);
        conv(16'd4, 3'b001);
        clear(32'h70);
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_events();
        t_set_wins();
        t_custom();
        t_limits();
        t_midreset();
        tally_and_finish();
    end

    initial begin
        #(2000 * 25);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
